/* smw_defs.svh */
// Constants for the static memory waveform generator
// Summary of operation
// RULE1 - 32-bit devices ignore address bits 0 and 1; 16-bit devices ignore bit 0.
// RULE2 - Byte-select type leaves write strobes 1-3 unused; byte-write leaves lane selects unused.
// RULE3 - Shared pins carry address, lane selects or byte strobes by width and type.
// RULE4 - Lane selects switch exactly with the address bus; the code drives them high between accesses while the address stays driven.
// RULE5 - Byte write strobes copy the single write strobe timing and protocol.
// RULE6 - Every access starts by driving the width-appropriate address bits.
// RULE7 - Read strobe falls after setup, stays low for pulse, then rises; address held.
// RULE8 - Read chip select has its own setup, pulse and hold counts.
// RULE9 - Read timings are per chip select, in whole master clock cycles.
// RULE10 - Read cycle length is programmed; holds follow from cycle minus setup and pulse.
// RULE11 - Zero setup and hold keep read signals asserted over back-to-back reads.
// RULE12 - Software programs every pulse count at least one.
// RULE13 - A per-chip-select read mode bit picks the capture signal; no comparison.
// RULE14 - Read mode 1 captures data on the edge raising the read strobe.
// RULE15 - Read mode 0 captures data on the edge raising the chip select.
// RULE16 - Write strobe falls after setup, stays low for pulse, rises; hold follows.
// RULE17 - Write chip select uses its own setup, pulse and hold counts.
// RULE18 - Write cycle length is programmed; holds follow from cycle minus setup and pulse.
// RULE19 - Zero setup keeps write signals asserted over back-to-back writes.
// RULE20 - Software gives SRAM-like chip selects a nonzero setup or hold.
// RULE21 - A per-chip-select write mode bit picks strobe or chip select control.
// RULE22 - Write mode 1 drives data from strobe setup end to cycle end.
// RULE23 - Write mode 0 drives data from chip select setup end to cycle end.
// RULE24 - Setup 6 bits, pulse 7, cycle 9; high bits add coarse 128 or 256 multiples.
// RULE25 - Each chip select has its own 8, 16 or 32 bit width.
// RULE26 - Software keeps setup plus pulse within the cycle value.
// RULE27 - Each access loads its chip select settings and counts master clock cycles.
`ifndef SMW_DEFS_SVH
`define SMW_DEFS_SVH
`define SMW_CLK_PERIOD_NS 40
`define SMW_SETUP_W       6
`define SMW_SETUP_LO_W    5
`define SMW_SETUP_MUL_LG  7
`define SMW_PULSE_W       7
`define SMW_PULSE_LO_W    6
`define SMW_PULSE_MUL_LG  8
`define SMW_CYCLE_W       9
`define SMW_CYCLE_LO_W    7
`define SMW_CYCLE_MUL_LG  8
`define SMW_EFF_W         10
`define SMW_ADDR_W        26
`define SMW_DATA_W        32
`define SMW_CS_IDX_W      3
`define SMW_PIN_IDLE      1'h1
`define SMW_ADDR_RST      24'h0
`define SMW_DATA_RST      32'h0
`define SMW_CNT_RST       10'h0
`endif

/* smw_pkg.sv */
// Types shared by the static memory waveform generator
package smw_pkg;
  `include "smw_defs.svh"
  typedef enum logic [1:0] {SMW_W8, SMW_W16, SMW_W32} smw_width_e;
  typedef enum logic {SMW_BYTE_SEL, SMW_BYTE_WR} smw_bat_e;
  typedef enum logic [1:0] {SMW_IDLE, SMW_ACCESS, SMW_GAP} smw_state_e;
  typedef struct packed {
    smw_width_e bus_width_sel;
    smw_bat_e   byte_access_type;
    logic       read_mode;
    logic       write_mode;
  } smw_mode_s;
  typedef struct packed {
    logic [`SMW_SETUP_W-1:0] rd_strobe_setup;
    logic [`SMW_SETUP_W-1:0] cs_read_setup;
    logic [`SMW_SETUP_W-1:0] wr_strobe_setup;
    logic [`SMW_SETUP_W-1:0] cs_write_setup;
    logic [`SMW_PULSE_W-1:0] rd_strobe_pulse;
    logic [`SMW_PULSE_W-1:0] cs_read_pulse;
    logic [`SMW_PULSE_W-1:0] wr_strobe_pulse;
    logic [`SMW_PULSE_W-1:0] cs_write_pulse;
    logic [`SMW_CYCLE_W-1:0] read_cycle_len;
    logic [`SMW_CYCLE_W-1:0] write_cycle_len;
  } smw_timing_s;
  typedef struct packed {
    logic [`SMW_CS_IDX_W-1:0] cs;
    logic                     wr;
    logic [`SMW_ADDR_W-1:0]   addr;
    logic [3:0]               be;
    logic [`SMW_DATA_W-1:0]   wdata;
  } smw_req_s;
  typedef struct packed {
    logic [`SMW_EFF_W-1:0] strobe_setup;
    logic [`SMW_EFF_W-1:0] strobe_end;
    logic [`SMW_EFF_W-1:0] cs_setup;
    logic [`SMW_EFF_W-1:0] cs_end;
    logic [`SMW_EFF_W-1:0] last;
  } smw_phase_s;
endpackage

/* smw_code_decode.sv */
// Timing code to effective cycle count decoder
`timescale 1ns/1ps
module smw_code_decode #(
  parameter int CODE_W = 6,
  parameter int LO_W   = 5,
  parameter int MUL_LG = 7,
  parameter int EFF_W  = 10
) (
  input  wire logic [CODE_W-1:0] i_code,
  output logic      [EFF_W-1:0]  o_eff
);
  // Coarse high bits scale by a power of two, low bits add directly
  assign o_eff = (EFF_W'(i_code[CODE_W-1:LO_W]) << MUL_LG) + EFF_W'(i_code[LO_W-1:0]); // RULE24
endmodule

/* smw_static_mem_ctrl.sv */
// Static memory waveform generator: access sequencer, pin sharing, read capture
`timescale 1ns/1ps
`include "smw_defs.svh"
module smw_static_mem_ctrl #(
  parameter int NUM_CS = 8
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_req_valid,
  input  wire smw_pkg::smw_req_s     i_req,
  output logic                       o_req_ready,
  input  wire smw_pkg::smw_mode_s    i_cs_mode [NUM_CS],
  input  wire smw_pkg::smw_timing_s  i_cs_timing [NUM_CS],
  input  wire logic [31:0]           i_data_in,
  output logic [31:0]                o_data_out,
  output logic                       o_data_oe,
  output logic [25:2]                o_addr_hi,
  output logic [NUM_CS-1:0]          o_chip_sel_n,
  output logic                       o_read_strobe_n,
  output logic                       o_lane0_or_addr0_pin,
  output logic                       o_write_or_byte0_pin,
  output logic                       o_lane1_or_byte1_pin,
  output logic                       o_lane2_byte2_addr1_pin,
  output logic                       o_lane3_or_byte3_pin,
  output logic                       o_rd_valid,
  output logic [31:0]                o_rd_data
);
  import smw_pkg::*;

  smw_state_e  state_q, state_d;
  logic [9:0]  cnt_q, cnt_d;
  smw_req_s    req_q, req_d;
  smw_mode_s   mode_q, mode_d;
  smw_phase_s  ph_q, ph_d;
  smw_phase_s  ph_new;
  smw_req_s    nxt;
  smw_mode_s   sel_mode;
  smw_timing_s sel_tim;
  logic        take;
  logic        last_cyc;
  logic        same_dev;
  logic        start;
  logic        ready_d;
  logic [5:0]  code_ss;
  logic [5:0]  code_cs;
  logic [6:0]  code_sp;
  logic [6:0]  code_cp;
  logic [8:0]  code_cy;
  logic [9:0]  eff_ss;
  logic [9:0]  eff_cs;
  logic [9:0]  eff_sp;
  logic [9:0]  eff_cp;
  logic [9:0]  eff_cy;

  // Request handshake and end-of-cycle detection
  assign take     = i_req_valid && o_req_ready;
  assign last_cyc = (state_q == SMW_ACCESS) && (cnt_q == ph_q.last);
  assign same_dev = (i_req.cs == req_q.cs) && (i_req.wr == req_q.wr);

  // Settings of the chip select about to start, read or write set
  always_comb begin
    nxt      = (state_q == SMW_GAP) ? req_q : i_req;
    sel_mode = i_cs_mode[nxt.cs]; // RULE25
    sel_tim  = i_cs_timing[nxt.cs]; // RULE9
    if (nxt.wr) begin
      code_ss = sel_tim.wr_strobe_setup; // RULE16
      code_cs = sel_tim.cs_write_setup; // RULE17
      code_sp = sel_tim.wr_strobe_pulse;
      code_cp = sel_tim.cs_write_pulse;
      code_cy = sel_tim.write_cycle_len; // RULE18
    end else begin
      code_ss = sel_tim.rd_strobe_setup; // RULE7
      code_cs = sel_tim.cs_read_setup; // RULE8
      code_sp = sel_tim.rd_strobe_pulse;
      code_cp = sel_tim.cs_read_pulse;
      code_cy = sel_tim.read_cycle_len; // RULE10
    end
  end

  // Code decoders, one per timing field in use
  smw_code_decode #(.CODE_W(`SMW_SETUP_W), .LO_W(`SMW_SETUP_LO_W), .MUL_LG(`SMW_SETUP_MUL_LG),
    .EFF_W(`SMW_EFF_W)) u_dec_ss (.i_code(code_ss), .o_eff(eff_ss));
  smw_code_decode #(.CODE_W(`SMW_SETUP_W), .LO_W(`SMW_SETUP_LO_W), .MUL_LG(`SMW_SETUP_MUL_LG),
    .EFF_W(`SMW_EFF_W)) u_dec_cs (.i_code(code_cs), .o_eff(eff_cs));
  smw_code_decode #(.CODE_W(`SMW_PULSE_W), .LO_W(`SMW_PULSE_LO_W), .MUL_LG(`SMW_PULSE_MUL_LG),
    .EFF_W(`SMW_EFF_W)) u_dec_sp (.i_code(code_sp), .o_eff(eff_sp));
  smw_code_decode #(.CODE_W(`SMW_PULSE_W), .LO_W(`SMW_PULSE_LO_W), .MUL_LG(`SMW_PULSE_MUL_LG),
    .EFF_W(`SMW_EFF_W)) u_dec_cp (.i_code(code_cp), .o_eff(eff_cp));
  smw_code_decode #(.CODE_W(`SMW_CYCLE_W), .LO_W(`SMW_CYCLE_LO_W), .MUL_LG(`SMW_CYCLE_MUL_LG),
    .EFF_W(`SMW_EFF_W)) u_dec_cy (.i_code(code_cy), .o_eff(eff_cy));

  // Phase boundaries; hold is implied by the cycle length, never stored
  always_comb begin
    ph_new.strobe_setup = eff_ss;
    ph_new.strobe_end   = eff_ss + eff_sp; // RULE10
    ph_new.cs_setup     = eff_cs;
    ph_new.cs_end       = eff_cs + eff_cp; // RULE18
    // A zero cycle code still yields a one-cycle access rather than a runaway count
    ph_new.last         = (eff_cy == `SMW_CNT_RST) ? `SMW_CNT_RST : eff_cy - 10'h001;
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    req_d   = req_q;
    mode_d  = mode_q;
    ph_d    = ph_q;
    start   = 1'b0;
    case (state_q)
      SMW_IDLE: begin
        if (take) begin
          start = 1'b1;
        end
      end
      SMW_ACCESS: begin
        if (!last_cyc) begin
          cnt_d = cnt_q + 10'h001; // RULE27
        end else if (take && same_dev) begin
          start = 1'b1; // RULE11 RULE19
        end else if (take) begin
          // Other device or direction: one idle cycle keeps drivers apart
          state_d = SMW_GAP;
          req_d   = i_req;
        end else begin
          state_d = SMW_IDLE;
        end
      end
      SMW_GAP: begin
        start = 1'b1;
      end
      default: begin
        state_d = SMW_IDLE;
      end
    endcase
    if (start) begin
      state_d = SMW_ACCESS;
      cnt_d   = `SMW_CNT_RST;
      req_d   = nxt; // RULE6
      mode_d  = sel_mode; // RULE27
      ph_d    = ph_new;
    end
    ready_d = (state_d == SMW_IDLE) || ((state_d == SMW_ACCESS) && (cnt_d == ph_d.last));
  end

  // Sequencer registers
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q     <= SMW_IDLE;
      cnt_q       <= `SMW_CNT_RST;
      req_q       <= '0;
      mode_q      <= '0;
      ph_q        <= '0;
      o_req_ready <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      req_q       <= req_d;
      mode_q      <= mode_d;
      ph_q        <= ph_d;
      o_req_ready <= ready_d;
    end
  end

  // Pin values for the next cycle, built from the sequencer's next state
  logic              act_d;
  logic              rd_on_d;
  logic              wr_on_d;
  logic              cs_on_d;
  logic [3:0]        lane_n_d;
  logic [3:0]        bwr_n_d;
  logic [NUM_CS-1:0] csn_d;
  logic              pin0_d;
  logic              pinwe_d;
  logic              pin1_d;
  logic              pin2_d;
  logic              pin3_d;
  logic              oe_d;
  logic              bw_d;

  always_comb begin
    act_d    = (state_d == SMW_ACCESS);
    rd_on_d  = act_d && !req_d.wr && (cnt_d >= ph_d.strobe_setup) && (cnt_d < ph_d.strobe_end); // RULE7
    wr_on_d  = act_d && req_d.wr && (cnt_d >= ph_d.strobe_setup) && (cnt_d < ph_d.strobe_end); // RULE16
    cs_on_d  = act_d && (cnt_d >= ph_d.cs_setup) && (cnt_d < ph_d.cs_end); // RULE8 RULE17
    csn_d    = '1;
    if (cs_on_d) begin
      csn_d[req_d.cs] = 1'b0;
    end
    // Lane selects follow the address for the whole access
    lane_n_d = act_d ? ~req_d.be : 4'hF; // RULE4
    // Each byte strobe is the write strobe gated by its lane
    bwr_n_d  = ~({4{wr_on_d}} & req_d.be); // RULE5
    bw_d     = (mode_d.byte_access_type == SMW_BYTE_WR) && (mode_d.bus_width_sel != SMW_W8);
    case (mode_d.bus_width_sel)
      SMW_W8: begin
        pin0_d = req_d.addr[0]; // RULE3
        pin1_d = `SMW_PIN_IDLE;
        pin2_d = req_d.addr[1];
        pin3_d = `SMW_PIN_IDLE;
      end
      SMW_W16: begin
        pin0_d = bw_d ? `SMW_PIN_IDLE : lane_n_d[0]; // RULE1 RULE2
        pin1_d = bw_d ? bwr_n_d[1] : lane_n_d[1]; // RULE2
        pin2_d = req_d.addr[1]; // RULE3
        pin3_d = `SMW_PIN_IDLE;
      end
      default: begin
        pin0_d = bw_d ? `SMW_PIN_IDLE : lane_n_d[0]; // RULE1 RULE2
        pin1_d = bw_d ? bwr_n_d[1] : lane_n_d[1];
        pin2_d = bw_d ? bwr_n_d[2] : lane_n_d[2]; // RULE3
        pin3_d = bw_d ? bwr_n_d[3] : lane_n_d[3];
      end
    endcase
    pinwe_d = bw_d ? bwr_n_d[0] : !wr_on_d; // RULE5
    // Drivers open at the end of the controlling signal's setup, close at cycle end
    oe_d    = act_d && req_d.wr &&
              (cnt_d >= (mode_d.write_mode ? ph_d.strobe_setup : ph_d.cs_setup)); // RULE21 RULE22 RULE23
  end

  // Pin registers; every external pin leaves straight from a flip-flop
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_chip_sel_n            <= '1;
      o_read_strobe_n         <= `SMW_PIN_IDLE;
      o_lane0_or_addr0_pin    <= `SMW_PIN_IDLE;
      o_write_or_byte0_pin    <= `SMW_PIN_IDLE;
      o_lane1_or_byte1_pin    <= `SMW_PIN_IDLE;
      o_lane2_byte2_addr1_pin <= `SMW_PIN_IDLE;
      o_lane3_or_byte3_pin    <= `SMW_PIN_IDLE;
      o_addr_hi               <= `SMW_ADDR_RST;
      o_data_out              <= `SMW_DATA_RST;
      o_data_oe               <= 1'b0;
    end else begin
      o_chip_sel_n            <= csn_d;
      o_read_strobe_n         <= !rd_on_d;
      o_lane0_or_addr0_pin    <= pin0_d;
      o_write_or_byte0_pin    <= pinwe_d;
      o_lane1_or_byte1_pin    <= pin1_d;
      o_lane2_byte2_addr1_pin <= pin2_d;
      o_lane3_or_byte3_pin    <= pin3_d;
      o_addr_hi               <= req_d.addr[25:2]; // RULE6
      o_data_out              <= req_d.wdata;
      o_data_oe               <= oe_d;
    end
  end

  // Read capture on the edge that ends the chosen signal's pulse.
  // The data bus is sampled directly: the strobe timing itself guarantees it is settled.
  logic        cap;
  logic        rd_valid_d;
  logic [31:0] rd_data_d;

  always_comb begin
    cap        = (state_q == SMW_ACCESS) && !req_q.wr &&
                 (cnt_q == ((mode_q.read_mode ? ph_q.strobe_end : ph_q.cs_end) - 10'h001)); // RULE13 RULE14 RULE15
    rd_valid_d = cap;
    rd_data_d  = cap ? i_data_in : o_rd_data;
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= `SMW_DATA_RST;
    end else begin
      o_rd_valid <= rd_valid_d;
      o_rd_data  <= rd_data_d;
    end
  end

  // Checks on the generated waveforms
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sequence seq_last_beat;
    (state_q == SMW_ACCESS) && (cnt_q == ph_q.last);
  endsequence

  sequence seq_read_active;
    (state_q == SMW_ACCESS) && !req_q.wr;
  endsequence

  chk_w32_no_addr: assert property ( // RULE1
    ((state_q == SMW_ACCESS) && (mode_q.bus_width_sel == SMW_W32) && (mode_q.byte_access_type == SMW_BYTE_SEL))
    |-> (o_lane0_or_addr0_pin == !req_q.be[0]) && (o_lane2_byte2_addr1_pin == !req_q.be[2]))
    else $error("32-bit access drives low address bits");

  chk_bw_lanes_idle: assert property ( // RULE2
    ((state_q == SMW_ACCESS) && (mode_q.byte_access_type == SMW_BYTE_WR) && (mode_q.bus_width_sel != SMW_W8))
    |-> o_lane0_or_addr0_pin)
    else $error("Lane select used in byte-write type");

  chk_w16_pin_map: assert property ( // RULE3
    ((state_q == SMW_ACCESS) && (mode_q.bus_width_sel == SMW_W16))
    |-> o_lane3_or_byte3_pin && (o_lane2_byte2_addr1_pin == req_q.addr[1]))
    else $error("16-bit pin sharing wrong");

  chk_lane_addr_sync: assert property ( // RULE4
    ((state_q == SMW_ACCESS) && $past(state_q == SMW_ACCESS) && (cnt_q != 10'h000)
     && (mode_q.bus_width_sel == SMW_W32) && (mode_q.byte_access_type == SMW_BYTE_SEL))
    |-> $stable(o_lane0_or_addr0_pin) && $stable(o_lane3_or_byte3_pin) && $stable(o_addr_hi))
    else $error("Lane select moved inside an access");

  chk_rd_strobe_win: assert property ( // RULE7
    seq_read_active |-> (o_read_strobe_n == !((cnt_q >= ph_q.strobe_setup) && (cnt_q < ph_q.strobe_end))))
    else $error("Read strobe outside its setup and pulse window");

  chk_rd_capture_strobe: assert property ( // RULE14
    ($rose(o_read_strobe_n) && $past(mode_q.read_mode) && $past(state_q == SMW_ACCESS)) |-> o_rd_valid)
    else $error("No capture on read strobe rise");

  chk_rd_capture_cs: assert property ( // RULE15
    (o_rd_valid && !$past(mode_q.read_mode)) |-> ($past(cnt_q) == $past(ph_q.cs_end) - 10'h001))
    else $error("Chip select capture on wrong edge");

  chk_wr_drive_win: assert property ( // RULE22
    ((state_q == SMW_ACCESS) && req_q.wr && mode_q.write_mode && (cnt_q >= ph_q.strobe_setup)) |-> o_data_oe)
    else $error("Data not driven after write strobe setup");

  chk_cycle_wrap: assert property ( // RULE10
    seq_last_beat |=> ((state_q != SMW_ACCESS) || (cnt_q == 10'h000)))
    else $error("Access ran past its cycle length");

  chk_wr_strobe_win: assert property ( // RULE16
    ((state_q == SMW_ACCESS) && req_q.wr && (mode_q.byte_access_type == SMW_BYTE_SEL))
    |-> (o_write_or_byte0_pin == !((cnt_q >= ph_q.strobe_setup) && (cnt_q < ph_q.strobe_end))))
    else $error("Write strobe outside its setup and pulse window");

  chk_cs_window: assert property ( // RULE8 RULE17
    (state_q == SMW_ACCESS) |-> (o_chip_sel_n[req_q.cs] == !((cnt_q >= ph_q.cs_setup) && (cnt_q < ph_q.cs_end))))
    else $error("Chip select outside its setup and pulse window");

  chk_wr_cs_drive: assert property ( // RULE23
    ((state_q == SMW_ACCESS) && req_q.wr && !mode_q.write_mode && (cnt_q >= ph_q.cs_setup)) |-> o_data_oe)
    else $error("Data not driven after chip select setup");

  chk_chain_held: assert property ( // RULE11 RULE19
    (last_cyc && take && same_dev && (i_req.be == req_q.be) && (ph_q.strobe_setup == 10'h000)
     && (ph_q.strobe_end == ph_q.last + 10'h001))
    |=> $stable(o_read_strobe_n) && $stable(o_write_or_byte0_pin) && $stable(o_lane1_or_byte1_pin))
    else $error("Strobe released between chained accesses");

  chk_addr_driven: assert property ( // RULE6
    (state_q == SMW_ACCESS) |-> (o_addr_hi == req_q.addr[25:2]))
    else $error("Address bus differs from the access address");

endmodule

/* smw_ext_mem.sv */
// Behavioural external static memory watching the controller's pins
`timescale 1ns/1ps
module smw_ext_mem (
  input  wire logic        i_ref_clk,
  input  wire logic        i_cs_n,
  input  wire logic        i_rd_n,
  input  wire logic [3:0]  i_wr_n,
  input  wire logic [25:2] i_addr_hi,
  input  wire logic [31:0] i_data_out,
  input  wire logic        i_data_oe,
  output logic      [31:0] o_data
);
  logic [31:0] mem [16];
  logic [31:0] last_q = 32'h0;
  // Known contents so that every read can be predicted
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 32'hA5C30000 + i;
  end
  // Driven only while selected or strobed; a released bus toggles so stale data never passes
  assign o_data = ((!i_cs_n || !i_rd_n) && !i_data_oe) ? mem[i_addr_hi[5:2]] : ~last_q;
  always @(posedge i_ref_clk) begin
    last_q <= o_data;
  end
  // Each byte latches on the rising edge of its own strobe, like an SRAM
  for (genvar k = 0; k < 4; k++) begin : g_lane
    always @(posedge i_wr_n[k]) begin
      if (i_cs_n === 1'b0 && i_data_oe === 1'b1) mem[i_addr_hi[5:2]][8*k +: 8] <= i_data_out[8*k +: 8];
    end
  end
endmodule

/* smw_static_mem_ctrl_test.sv */
// Self-checking bench for the static memory waveform generator
`timescale 1ns/1ps
module smw_static_mem_ctrl_test;
  import smw_pkg::*;
  logic        ref_clk = 1'h0;
  logic        reset = 1'h1;
  logic        req_valid = 1'h0;
  smw_req_s    req = '0;
  smw_mode_s   cs_mode [8];
  smw_timing_s cs_timing [8];
  logic [31:0] data_in, data_out, rd_data, got_rd, got_wd;
  logic [25:2] addr_hi;
  logic [23:0] got_addr;
  logic [7:0]  chip_sel_n;
  logic [4:0]  pin;
  logic        data_oe, req_ready, rd_strobe_n, rd_valid;
  int          fails = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          first [10];
  int          cnt [10];

  smw_static_mem_ctrl u_dut (
    .i_ref_clk(ref_clk), .i_reset(reset), .i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready),
    .i_cs_mode(cs_mode), .i_cs_timing(cs_timing), .i_data_in(data_in), .o_data_out(data_out),
    .o_data_oe(data_oe), .o_addr_hi(addr_hi), .o_chip_sel_n(chip_sel_n), .o_read_strobe_n(rd_strobe_n),
    .o_lane0_or_addr0_pin(pin[0]), .o_write_or_byte0_pin(pin[1]), .o_lane1_or_byte1_pin(pin[2]),
    .o_lane2_byte2_addr1_pin(pin[3]), .o_lane3_or_byte3_pin(pin[4]), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data));

  smw_ext_mem u_mem (
    .i_ref_clk(ref_clk), .i_cs_n(&chip_sel_n), .i_rd_n(rd_strobe_n), .i_wr_n(pin[4:1]),
    .i_addr_hi(addr_hi), .i_data_out(data_out), .i_data_oe(data_oe), .o_data(data_in));

  // Free-running 25 MHz clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      finish_test();
    end
  end

  function automatic logic [31:0] pat(input int i);
    return 32'hA5C30000 + i;
  endfunction

  task automatic chk_int(input string name, input int exp, input int got);
    tests_run++;
    if (exp != got) begin
      fails++;
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic chk_vec(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Hold the request from a falling edge until the edge that takes it
  task automatic issue(input logic [2:0] cs, input logic wr, input logic [25:0] addr, input logic [3:0] be,
                       input logic [31:0] wd);
    int n;
    n = 0;
    req = '{cs, wr, addr, be, wd};
    req_valid = 1'h1;
    while (req_ready !== 1'h1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    chk_int("request taken", 1, int'(n < 50));
    @(posedge ref_clk);
    @(negedge ref_clk);
    req_valid = 1'h0;
  endtask

  // Samples n cycles from count 0: first active cycle and active count of each pin
  task automatic watch(input int cs, input int n);
    logic [9:0] w;
    for (int i = 0; i < 10; i++) begin
      first[i] = -1;
      cnt[i] = 0;
    end
    for (int k = 0; k < n; k++) begin
      if (k > 0) @(negedge ref_clk);
      w = {~req_ready, ~rd_valid, ~data_oe, pin, chip_sel_n[cs], rd_strobe_n};
      if (k == 0) got_addr = addr_hi;
      if (rd_valid === 1'b1) got_rd = rd_data;
      if (data_oe === 1'b1) got_wd = data_out;
      for (int i = 0; i < 10; i++) begin
        if (w[i] !== 1'b1) begin
          if (first[i] < 0) first[i] = k;
          cnt[i]++;
        end
      end
    end
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic chk_all(input string tag, input int e [20]);
    string nm [10] = '{"read_strobe", "chip_sel", "lane0_or_addr0", "write_or_byte0", "lane1_or_byte1",
                       "lane2_byte2_addr1", "lane3_or_byte3", "data_oe", "rd_valid", "req_ready"};
    for (int i = 0; i < 10; i++) begin
      chk_int({tag, " ", nm[i], " first"}, e[2*i], first[i]);
      chk_int({tag, " ", nm[i], " count"}, e[2*i+1], cnt[i]);
    end
  endtask

  task automatic t_read_rd_ctrl();
    issue(3'h0, 1'h0, 26'h000000C, 4'h6, 32'h0);
    watch(0, 4);
    chk_all("rd_ctrl", '{1, 2, 0, 4, -1, 0, -1, 0, 0, 4, 0, 4, -1, 0, -1, 0, 3, 1, 3, 1});
    chk_vec("rd_ctrl addr", 32'h3, {8'h00, got_addr});
    chk_vec("rd_ctrl data", pat(3), got_rd);
    $display("test read_rd_ctrl done");
  endtask

  task automatic t_read_cs_ctrl();
    issue(3'h1, 1'h0, 26'h000001E, 4'h2, 32'h0);
    watch(1, 5);
    chk_all("cs_ctrl", '{0, 3, 1, 3, -1, 0, -1, 0, 0, 5, -1, 0, -1, 0, -1, 0, 4, 1, 4, 1});
    chk_vec("cs_ctrl addr", 32'h7, {8'h00, got_addr});
    chk_vec("cs_ctrl data", pat(7), got_rd);
    $display("test read_cs_ctrl done");
  endtask

  task automatic t_write_byte();
    issue(3'h2, 1'h1, 26'h0000014, 4'h5, 32'h11223344);
    watch(2, 5);
    chk_all("wr_byte", '{-1, 0, 0, 5, -1, 0, 1, 2, -1, 0, 1, 2, -1, 0, 1, 4, -1, 0, 4, 1});
    chk_vec("wr_byte data", 32'h11223344, got_wd);
    issue(3'h0, 1'h0, 26'h0000014, 4'hF, 32'h0);
    watch(0, 4);
    chk_all("readback", '{1, 2, 0, 4, 0, 4, -1, 0, 0, 4, 0, 4, 0, 4, -1, 0, 3, 1, 3, 1});
    chk_vec("readback data", (pat(5) & 32'hFF00FF00) | 32'h00220044, got_rd);
    $display("test write_byte done");
  endtask

  task automatic t_write_cs_ctrl();
    issue(3'h3, 1'h1, 26'h0000025, 4'h1, 32'h0000005A);
    watch(3, 5);
    chk_all("wr_cs", '{-1, 0, 1, 3, -1, 0, 2, 1, -1, 0, 0, 5, -1, 0, 1, 4, -1, 0, 4, 1});
    chk_vec("wr_cs addr", 32'h9, {8'h00, got_addr});
    chk_vec("wr_cs data", 32'h0000005A, got_wd);
    $display("test write_cs_ctrl done");
  endtask

  task automatic t_chain();
    issue(3'h4, 1'h0, 26'h0000004, 4'hF, 32'h0);
    fork
      watch(4, 5);
      issue(3'h4, 1'h0, 26'h0000008, 4'hF, 32'h0);
    join
    chk_all("chain", '{0, 4, 0, 4, 0, 4, -1, 0, 0, 4, 0, 4, 0, 4, -1, 0, 2, 2, 1, 3});
    chk_vec("chain data", pat(2), got_rd);
    $display("test chain done");
  endtask

  task automatic t_coded();
    issue(3'h5, 1'h0, 26'h0000010, 4'hF, 32'h0);
    watch(5, 516);
    chk_all("coded", '{129, 257, 128, 256, 0, 516, -1, 0, 0, 516, 0, 516, 0, 516, -1, 0, 386, 1, 515, 1});
    chk_vec("coded data", pat(4), got_rd);
    $display("test coded done");
  endtask

  // Different chip select in the last beat: one idle cycle, then the new access
  task automatic t_gap();
    issue(3'h4, 1'h0, 26'h0000004, 4'hF, 32'h0);
    fork
      watch(0, 8);
      issue(3'h0, 1'h0, 26'h0000018, 4'hF, 32'h0);
    join
    chk_all("gap", '{0, 4, 3, 4, 0, 6, -1, 0, 0, 6, 0, 6, 0, 6, -1, 0, 2, 2, 1, 3});
    chk_vec("gap data", pat(6), got_rd);
    $display("test gap done");
  endtask

  // Chained 16-bit byte-write accesses with null setup and hold
  task automatic t_wr_chain();
    issue(3'h6, 1'h1, 26'h0000030, 4'h3, 32'h0000A55A);
    fork
      watch(6, 5);
      issue(3'h6, 1'h1, 26'h0000032, 4'h3, 32'h00003CC3);
    join
    chk_all("wr_chain", '{-1, 0, 0, 4, -1, 0, 0, 4, 0, 4, 0, 2, -1, 0, 0, 4, -1, 0, 1, 3});
    chk_vec("wr_chain data", 32'h00003CC3, got_wd);
    $display("test wr_chain done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Static per-device settings: every pulse at least one, setup plus pulse within the cycle
  initial begin
    for (int i = 0; i < 8; i++) begin
      cs_mode[i] = '{SMW_W32, SMW_BYTE_SEL, 1'h1, 1'h1};
      cs_timing[i] = '{6'h00, 6'h00, 6'h00, 6'h00, 7'h01, 7'h01, 7'h01, 7'h01, 9'h001, 9'h001};
    end
    cs_mode[1] = '{SMW_W16, SMW_BYTE_SEL, 1'h0, 1'h1};
    cs_mode[2] = '{SMW_W32, SMW_BYTE_WR, 1'h1, 1'h1};
    cs_mode[3] = '{SMW_W8, SMW_BYTE_SEL, 1'h1, 1'h0};
    cs_timing[0] = '{6'h01, 6'h00, 6'h00, 6'h00, 7'h02, 7'h04, 7'h01, 7'h01, 9'h004, 9'h001};
    cs_timing[1] = '{6'h00, 6'h01, 6'h00, 6'h00, 7'h03, 7'h03, 7'h01, 7'h01, 9'h005, 9'h001};
    cs_timing[2] = '{6'h00, 6'h00, 6'h01, 6'h00, 7'h01, 7'h01, 7'h02, 7'h05, 9'h001, 9'h005};
    cs_timing[3] = '{6'h00, 6'h00, 6'h02, 6'h01, 7'h01, 7'h01, 7'h01, 7'h03, 9'h001, 9'h005};
    cs_timing[4] = '{6'h00, 6'h00, 6'h00, 6'h00, 7'h02, 7'h02, 7'h01, 7'h01, 9'h002, 9'h001};
    cs_timing[5] = '{6'h21, 6'h20, 6'h00, 6'h00, 7'h41, 7'h40, 7'h01, 7'h01, 9'h104, 9'h001};
    // A peripheral that latches on the falling strobe, so null setup and hold are legal here
    cs_mode[6] = '{SMW_W16, SMW_BYTE_WR, 1'h1, 1'h1};
    cs_timing[6] = '{6'h00, 6'h00, 6'h00, 6'h00, 7'h01, 7'h01, 7'h02, 7'h02, 9'h001, 9'h002};
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'h0;
    @(negedge ref_clk);
    t_read_rd_ctrl();
    t_read_cs_ctrl();
    t_write_byte();
    t_write_cs_ctrl();
    t_chain();
    t_coded();
    t_gap();
    t_wr_chain();
    finish_test();
  end
endmodule
